/* bench/serial_transmitter_parity_bench.sv */
/* Bench of the serial transmitter: register tasks, far-end model, frame checks.
   Assumes the design, receiver model and monitor are compiled before it. */
`timescale 1ns/10ps
module serial_transmitter_parity_bench;
    import sxtp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    sxtp_byte_t regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    sxtp_byte_t regRdata;
    logic syncClockPin = 1'b0;
    logic syncRun = 1'b0;
    logic serialOutPin;
    logic serialOutEn;
    logic lineLvl;
    logic [3:0] frameLen = 4'hA;
    logic [7:0] bitLen = 8'h10;
    logic [11:0] frameBits;
    int frames;
    int failures = 0;
    int compares = 0;
    // double-rate bit kept by the done-flag clear that precedes every send
    sxtp_byte_t csaKeep = 8'h00;
    sxtp_byte_t rstTab [7] = '{8'h00, 8'h20, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00};
    always #5 clk = ~clk;
    // far-end clock stands still unless a sync frame is wanted
    always #40 syncClockPin <= syncRun & ~syncClockPin;
    // pull-up holds the line when the pin is released
    assign lineLvl = serialOutEn ? serialOutPin : 1'b1;
    sxtp_transmitter i_sxtp_transmitter (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .syncClockPin(syncClockPin), .serialOutPin(serialOutPin), .serialOutEn(serialOutEn));
    sxtp_rx_model i_sxtp_rx_model (.clk(clk), .lineIn(lineLvl), .frameLen(frameLen),
        .bitLen(bitLen), .frameBits(frameBits), .frames(frames));
    task automatic finish_test();
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input sxtp_byte_t d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output sxtp_byte_t d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
        @(posedge clk);
    endtask
    task automatic waitFrame(input int n);
        for (int k = 0; frames < n; k++) begin
            if (k == 3000) begin
                failures++;
                finish_test();
            end
            @(posedge clk);
        end
    endtask
    task automatic poll(input int b);
        sxtp_byte_t v;
        for (int k = 0; k < 300; k++) begin
            rd(4'h1, v);
            if (v[b]) return;
        end
        failures++;
        finish_test();
    endtask
    // expected line bits, first bit sent in bit 0
    function automatic logic [11:0] frame(input logic [8:0] d, input int n, input int pe,
        input logic po, input int st);
        logic [11:0] f;
        f = 12'hFFE;
        for (int i = 0; i < n; i++) f[i + 1] = d[i];
        if (pe != 0) f[n + 1] = po ^ (^(d & ((9'h001 << n) - 9'h001)));
        return f & ((12'h001 << (n + 1 + pe + st)) - 12'h001);
    endfunction
    task automatic send(input sxtp_byte_t c, input sxtp_byte_t b, input sxtp_byte_t d,
        input logic [11:0] e, input logic [3:0] n);
        sxtp_byte_t v;
        int f;
        wr(4'h1, csaKeep | 8'h40);
        wr(4'h3, c);
        rd(4'h3, v);
        check(v, c);
        wr(4'h2, b);
        frameLen <= n;
        f = frames + 1;
        wr(4'h0, d);
        waitFrame(f);
        check(frameBits & ((12'h001 << n) - 12'h001), e);
        poll(6);
    endtask
    initial begin
        sxtp_byte_t v;
        int n;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(4'h6, 8'hFF);
        for (int a = 0; a < 7; a++) begin
            rd(a[3:0], v);
            check(v, rstTab[a]);
        end
        wr(4'h5, 8'h00);
        wr(4'h4, 8'h00);
        wr(4'h2, 8'h08);
        #1 check(serialOutEn, 1'b1);
        send(8'h06, 8'h08, 8'hA5, frame(9'h0A5, 8, 0, 0, 1), 4'hA);
        poll(6);
        rd(4'h1, v);
        check(v, 8'h60);
        wr(4'h1, 8'h40);
        rd(4'h1, v);
        check(v, 8'h20);
        for (int i = 0; i < 4; i++) begin
            v = i[1] ? 8'h3C : 8'h6B;
            send(8'h2E | {3'h0, i[0], 4'h0}, 8'h08, v, frame({1'b0, v}, 8, 1, i[0], 2),
                4'hC);
        end
        send(8'h00, 8'h08, 8'hE3, frame(9'h003, 5, 0, 0, 1), 4'h7);
        send(8'h32, 8'h08, 8'hED, frame(9'h02D, 6, 1, 1, 1), 4'h9);
        send(8'h06, 8'h0D, 8'h3C, frame(9'h13C, 9, 0, 0, 1), 4'hB);
        wr(4'h2, 8'h08);
        frameLen <= 4'hA;
        n = frames;
        wr(4'h0, 8'h81);
        poll(5);
        wr(4'h0, 8'h7E);
        waitFrame(n + 1);
        check(frameBits[9:0], frame(9'h081, 8, 0, 0, 1));
        waitFrame(n + 2);
        check(frameBits[9:0], frame(9'h07E, 8, 0, 0, 1));
        n = frames;
        wr(4'h0, 8'h55);
        wr(4'h2, 8'h00);
        #1 check(serialOutEn, 1'b1);
        waitFrame(n + 1);
        check(frameBits[9:0], frame(9'h055, 8, 0, 0, 1));
        repeat (40) @(posedge clk);
        #1 check(serialOutEn, 1'b0);
        wr(4'h1, 8'h40);
        n = frames;
        wr(4'h0, 8'h12);
        repeat (300) @(posedge clk);
        check(12'(frames), 12'(n));
        wr(4'h2, 8'h08);
        waitFrame(n + 1);
        check(frameBits[9:0], frame(9'h012, 8, 0, 0, 1));
        poll(6);
        csaKeep = 8'h02;
        bitLen <= 8'h08;
        send(8'h06, 8'h08, 8'h3A, frame(9'h03A, 8, 0, 0, 1), 4'hA);
        csaKeep = 8'h00;
        syncRun <= 1'b1;
        send(8'h46, 8'h08, 8'hC3, frame(9'h0C3, 8, 0, 0, 1), 4'hA);
        send(8'h47, 8'h08, 8'h5A, frame(9'h05A, 8, 0, 0, 1), 4'hA);
        syncRun <= 1'b0;
        finish_test();
    end
endmodule
bind sxtp_transmitter sxtp_tx_monitor i_sxtp_tx_monitor (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .serialOutPin(serialOutPin), .serialOutEn(serialOutEn));

/* bench/sxtp_rx_model.sv */
/* Far-end receiver model: samples the line at mid-bit, keeps the last frame.
   Assumes the bench sets bit length in clocks and frame length in bits. */
`timescale 1ns/10ps
module sxtp_rx_model (
    // clock
    input wire logic clk,
    // line and format
    input wire logic lineIn,
    input wire logic [3:0] frameLen,
    input wire logic [7:0] bitLen,
    // captured frame
    output logic [11:0] frameBits,
    output int frames
);
    initial begin
        frameBits = 12'h000;
        frames = 0;
        forever begin
            @(negedge lineIn);
            // mid-bit sampling absorbs the tick latency of sync mode
            repeat (bitLen / 2) @(posedge clk);
            for (int i = 0; i < frameLen; i++) begin
                frameBits[i] = lineIn;
                // no wait after the last stop: a next start may follow at once
                if (i < frameLen - 1) repeat (bitLen) @(posedge clk);
            end
            frames++;
        end
    end
endmodule

/* bench/sxtp_tx_monitor.sv */
/* Checker of the transmitter's port timing.
   Assumes it is bound to the transmitter from the bench top. */
`timescale 1ns/10ps
module sxtp_tx_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire sxtp_pkg::sxtp_byte_t regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire sxtp_pkg::sxtp_byte_t regRdata,
    // serial pins
    input wire logic serialOutPin,
    input wire logic serialOutEn
);
    import sxtp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_cscWr;
        regWrite && regAddr == 4'h3 ##1 !(regWrite && regAddr == 4'h3)
            ##1 regRead && regAddr == 4'h3;
    endsequence
    sequence s_low4; !serialOutPin [*4]; endsequence
    property p_dataRd; regRead && regAddr == 4'h0 |=> regRdata == 8'h00; endproperty
    a_dataRd: assert property (p_dataRd) else $error("data port read back");
    property p_cscEcho; s_cscWr |=> regRdata[6:0] == $past(regWdata[6:0], 3); endproperty
    a_cscEcho: assert property (p_cscEcho) else $error("format readback wrong");
    property p_enOn; regWrite && regAddr == 4'h2 && regWdata[3] |-> ##[1:3] serialOutEn; endproperty
    a_enOn: assert property (p_enOn) else $error("pin not taken");
    property p_idleHigh; !serialOutEn |-> serialOutPin; endproperty
    a_idleHigh: assert property (p_idleHigh) else $error("released line low");
    property p_lowLen; $fell(serialOutPin) |-> s_low4; endproperty
    a_lowLen: assert property (p_lowLen) else $error("low bit too short");
    property p_bitSteady; $changed(serialOutPin) |=> $stable(serialOutPin) [*3]; endproperty
    a_bitSteady: assert property (p_bitSteady) else $error("bit changed early");
    property p_relHigh; $fell(serialOutEn) |-> $past(serialOutPin); endproperty
    a_relHigh: assert property (p_relHigh) else $error("released mid bit");
    property p_enHold; serialOutEn && !serialOutPin |=> serialOutEn; endproperty
    a_enHold: assert property (p_enHold) else $error("released in frame");
endmodule

/* rtl/sxtp_bit_timer.sv */
/*
 * Bit timer: baud divisor down-counter and bit-period prescaler, or edge
 * detection of the external synchronous clock; gives one-cycle bit ticks.
 * Assumes the external clock pin is asynchronous to clk.
 */
`timescale 1ns/10ps
`include "sxtp_consts.svh"
module sxtp_bit_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic [11:0] baudDivisor,
    input wire logic baudReload,
    input wire logic doubleRate,
    input wire logic syncMode,
    input wire logic clkPolarity,
    input wire logic syncClockPin,
    // tick out
    output logic bitTick
);
    import sxtp_pkg::*;

    typedef struct packed {
        logic [11:0] cnt;
        logic [4:0] pre;
        logic [1:0] sync;
        logic syncPrev;
        logic tick;
    } sxtp_timer_t;

    sxtp_timer_t s_q, s_d;
    logic slave;
    logic [4:0] div;

    // slave synchronous: the external pin is the only bit clock
    assign slave = syncMode;
    assign div = doubleRate ? `SXTP_DIV_DOUBLE : `SXTP_DIV_NORMAL;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.sync = {s_q.sync[0], syncClockPin};
        s_d.syncPrev = s_q.sync[1];
        if (slave) begin
            // data change edge chosen by polarity; costs three cycles of latency [RULE4]
            if (clkPolarity ? (s_q.syncPrev & ~s_q.sync[1]) : (~s_q.syncPrev & s_q.sync[1])) begin
                s_d.tick = 1'b1; // [RULE7]
            end
        end else if (baudReload || s_q.cnt == 12'h000) begin
            s_d.cnt = baudDivisor;
            if (s_q.pre + 5'h01 >= div) begin
                s_d.pre = 5'h00;
                s_d.tick = 1'b1; // [RULE7]
            end else begin
                s_d.pre = s_q.pre + 5'h01;
            end
        end else begin
            s_d.cnt = s_q.cnt - 12'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bitTick = s_q.tick;
endmodule

/* rtl/sxtp_consts.svh */
/*
 * Constants of the serial transmitter with parity: register offsets, field
 * positions, reset values and timing figures.
 * Assumes it is included by bare name by the design modules.
 */
// Notes on behaviour
// [RULE1] parity is xor of all data bits, inverted when odd parity chosen
// [RULE2] parity bit sits after last data bit, before first stop bit
// [RULE3] tx_on_bit set hands serial_out_pin to the transmitter
// [RULE4] synchronous mode takes sync_clock_pin as the transmission clock
// [RULE5] writing tx_data_port fills the one-deep buffer until shifter takes it
// [RULE6] buffer moves to shifter when idle or right after last stop bit
// [RULE7] loaded shifter sends one frame at divisor/double-rate or external clock rate
// [RULE8] upper bits above character size are ignored
// [RULE9] software writes ninth_tx_bit before the low byte for 9-bit characters
// [RULE10] polling software waits for buffer_empty_flag before writing
// [RULE11] buffer-empty handler supplies the next character
// [RULE12] software sets baud, format and enables before communicating
// [RULE13] software should mask global interrupts while initializing
// [RULE14] software checks done flags before changing baud or format
// [RULE15] software clears tx_done_flag before each write when using it
// [RULE16] size code 3 with high bit clear is eight bits; stop_count_bit gives two stops
// [RULE17] buffer_empty_flag set when buffer empty, cleared by data write
// [RULE18] tx_done_flag set when frame sent and buffer empty; write one clears
// [RULE19] start bit then data lsb first; idle line high
// [RULE20] disabling waits for pending data, then releases the pin
// [RULE21] start bit low, stop bits high, each held one full bit period
// [RULE22] ninth_tx_bit sampled at shifter load, sent as data msb
`ifndef SXTP_CONSTS_SVH
`define SXTP_CONSTS_SVH

// register offsets
`define SXTP_OFS_DATA 4'h0
`define SXTP_OFS_CSA 4'h1
`define SXTP_OFS_CSB 4'h2
`define SXTP_OFS_CSC 4'h3
`define SXTP_OFS_BAUDL 4'h4
`define SXTP_OFS_BAUDH 4'h5

// ctrl_status_a
`define SXTP_A_DONE 6
`define SXTP_A_EMPTY 5
`define SXTP_A_DBL 1
// ctrl_status_b
`define SXTP_B_TXON 3
`define SXTP_B_SIZE2 2
`define SXTP_B_NINTH 0
// ctrl_status_c
`define SXTP_C_SYNC 6
`define SXTP_C_PEN 5
`define SXTP_C_PODD 4
`define SXTP_C_STOP2 3
`define SXTP_C_SIZE_HI 2
`define SXTP_C_SIZE_LO 1
`define SXTP_C_POL 0

// reset values and the 9-bit size code
`define SXTP_RST_CSC 8'h06
`define SXTP_RST_BAUD 12'h000
`define SXTP_SIZE_9BIT 3'h7

// bit timing: baud divisor periods per bit tick; the sync mode figure is not used by the timer
`define SXTP_DIV_NORMAL 5'h10
`define SXTP_DIV_DOUBLE 5'h08
`define SXTP_DIV_SYNC 5'h02

`endif

/* rtl/sxtp_pkg.sv */
/*
 * Types of the serial transmitter with parity.
 * Assumes the constants header sits beside it.
 */
package sxtp_pkg;
    typedef enum logic [2:0] {SXTP_IDLE, SXTP_START, SXTP_DATA, SXTP_PAR, SXTP_STOP} sxtp_state_t;
    typedef logic [7:0] sxtp_byte_t;
endpackage

/* rtl/sxtp_transmitter.sv */
/*
 * Transmitter: register file, one-deep transmit buffer, shift register with
 * parity insertion, done/empty flags and serial pin takeover.
 * Assumes a register master with one-cycle strobes and read data one cycle
 * later; the synchronous clock pin is asynchronous to clk.
 */
`timescale 1ns/10ps
`include "sxtp_consts.svh"
module sxtp_transmitter (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire sxtp_pkg::sxtp_byte_t regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output sxtp_pkg::sxtp_byte_t regRdata,
    // serial pins
    input wire logic syncClockPin,
    output logic serialOutPin,
    output logic serialOutEn
);
    import sxtp_pkg::*;

    typedef struct packed {
        logic [7:0] bufData;
        logic bufNinth;
        logic bufFull;
        logic [8:0] shift;
        logic [3:0] bitsLeft;
        logic stopsLeft;
        logic parity;
        sxtp_state_t st;
        logic done;
        logic dbl;
        logic txOn;
        logic ninth;
        logic [7:0] csc;
        logic [11:0] baud;
        logic outBit;
        logic outEn;
        logic [7:0] rdata;
    } sxtp_tx_t;

    sxtp_tx_t s_q, s_d;
    logic bitTick;
    logic baudReload;

    function automatic logic [3:0] charBits(input logic hi, input logic [1:0] lo);
        // [RULE16] code 3 with hi clear -> 8 bits; hi with 3 -> 9 bits
        charBits = hi ? 4'h9 : 4'h5 + {2'b00, lo};
    endfunction

    function automatic logic wr(input logic [3:0] a, input logic [3:0] ofs, input logic we);
        wr = we && (a == ofs);
    endfunction

    assign baudReload = wr(regAddr, `SXTP_OFS_BAUDL, regWrite);

    sxtp_bit_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .baudDivisor(s_q.baud),
        .baudReload(baudReload),
        .doubleRate(s_q.dbl),
        .syncMode(s_q.csc[`SXTP_C_SYNC]),
        .clkPolarity(s_q.csc[`SXTP_C_POL]),
        .syncClockPin(syncClockPin),
        .bitTick(bitTick)
    );

    always_comb begin
        logic [3:0] nBits;
        logic [8:0] masked;
        logic doneSet;
        logic txLive;
        nBits = charBits(s_q.ninth, s_q.csc[`SXTP_C_SIZE_HI:`SXTP_C_SIZE_LO]);
        masked = '0;
        doneSet = 1'b0;
        txLive = s_q.txOn | s_q.outEn; // [RULE20]
        s_d = s_q;

        // register writes
        if (wr(regAddr, `SXTP_OFS_DATA, regWrite)) begin
            s_d.bufData = regWdata; // [RULE5]
            s_d.bufFull = 1'b1; // [RULE17]
        end
        if (wr(regAddr, `SXTP_OFS_CSA, regWrite)) begin
            s_d.dbl = regWdata[`SXTP_A_DBL];
        end
        if (wr(regAddr, `SXTP_OFS_CSB, regWrite)) begin
            s_d.txOn = regWdata[`SXTP_B_TXON];
            s_d.bufNinth = regWdata[`SXTP_B_NINTH];
        end
        if (wr(regAddr, `SXTP_OFS_CSC, regWrite)) begin
            s_d.csc = regWdata;
        end
        if (baudReload) begin
            s_d.baud[7:0] = regWdata;
        end
        if (wr(regAddr, `SXTP_OFS_BAUDH, regWrite)) begin
            s_d.baud[11:8] = regWdata[3:0];
        end

        // shifter; each step waits one full bit tick [RULE21]
        if (bitTick) begin
            case (s_q.st)
                SXTP_IDLE: begin
                    s_d.outBit = 1'b1; // [RULE19]
                end
                SXTP_START: begin
                    s_d.outBit = s_q.shift[0]; // [RULE19]
                    s_d.shift = {1'b0, s_q.shift[8:1]};
                    s_d.bitsLeft = s_q.bitsLeft - 4'h1;
                    s_d.st = SXTP_DATA;
                end
                SXTP_DATA: begin
                    if (s_q.bitsLeft != 4'h0) begin
                        s_d.outBit = s_q.shift[0];
                        s_d.shift = {1'b0, s_q.shift[8:1]};
                        s_d.bitsLeft = s_q.bitsLeft - 4'h1;
                    end else if (s_q.csc[`SXTP_C_PEN]) begin
                        s_d.outBit = s_q.parity; // [RULE2]
                        s_d.st = SXTP_PAR;
                    end else begin
                        s_d.outBit = 1'b1; // [RULE21]
                        s_d.st = SXTP_STOP;
                    end
                end
                SXTP_PAR: begin
                    s_d.outBit = 1'b1; // [RULE2]
                    s_d.st = SXTP_STOP;
                end
                SXTP_STOP: begin
                    if (s_q.stopsLeft) begin
                        s_d.stopsLeft = 1'b0; // [RULE16]
                    end else begin
                        s_d.st = SXTP_IDLE;
                        doneSet = ~s_q.bufFull; // [RULE18]
                    end
                end
                default: s_d.st = SXTP_IDLE;
            endcase
        end

        // load from buffer when idle or right after the last stop bit [RULE6]
        // a cleared tx_on_bit still lets the pending character out before release
        if (s_d.st == SXTP_IDLE && s_q.bufFull && txLive && bitTick) begin
            masked = {s_q.bufNinth, s_q.bufData}; // [RULE22]
            for (int i = 0; i < 9; i++) begin
                if (i >= nBits) begin
                    masked[i] = 1'b0; // [RULE8]
                end
            end
            s_d.shift = masked;
            s_d.parity = (^masked) ^ s_q.csc[`SXTP_C_PODD]; // [RULE1]
            s_d.bitsLeft = nBits;
            s_d.stopsLeft = s_q.csc[`SXTP_C_STOP2]; // [RULE16]
            s_d.outBit = 1'b0; // [RULE21]
            s_d.st = SXTP_START; // [RULE7]
            s_d.bufFull = wr(regAddr, `SXTP_OFS_DATA, regWrite);
        end

        // set wins over a write-one clear
        if (wr(regAddr, `SXTP_OFS_CSA, regWrite) && regWdata[`SXTP_A_DONE]) begin
            s_d.done = 1'b0;
        end
        if (doneSet) begin
            s_d.done = 1'b1; // [RULE18]
        end

        // pin held until nothing is pending after a disable [RULE20]
        if (s_q.txOn) begin
            s_d.outEn = 1'b1; // [RULE3]
        end else if (s_d.st == SXTP_IDLE && !s_q.bufFull) begin
            s_d.outEn = 1'b0; // [RULE20]
            s_d.outBit = 1'b1;
        end

        s_d.rdata = 8'h00;
        if (regRead) begin
            case (regAddr)
                `SXTP_OFS_CSA: begin
                    s_d.rdata[`SXTP_A_DONE] = s_q.done;
                    s_d.rdata[`SXTP_A_EMPTY] = ~s_q.bufFull; // [RULE17]
                    s_d.rdata[`SXTP_A_DBL] = s_q.dbl;
                end
                `SXTP_OFS_CSB: begin
                    s_d.rdata[`SXTP_B_TXON] = s_q.txOn;
                    s_d.rdata[`SXTP_B_SIZE2] = s_q.ninth;
                    s_d.rdata[`SXTP_B_NINTH] = s_q.bufNinth;
                end
                `SXTP_OFS_CSC: s_d.rdata = s_q.csc;
                `SXTP_OFS_BAUDL: s_d.rdata = s_q.baud[7:0];
                `SXTP_OFS_BAUDH: s_d.rdata = {4'h0, s_q.baud[11:8]};
                default: s_d.rdata = 8'h00;
            endcase
        end
        // high size bit lives in ctrl_status_b; loaded by each ctrl_status_b write, kept otherwise
        if (wr(regAddr, `SXTP_OFS_CSB, regWrite)) begin
            s_d.ninth = regWdata[`SXTP_B_SIZE2];
        end else begin
            s_d.ninth = s_q.ninth;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.csc <= `SXTP_RST_CSC;
            s_q.baud <= `SXTP_RST_BAUD;
            s_q.outBit <= 1'b1;
            s_q.st <= SXTP_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata = s_q.rdata;
    assign serialOutPin = s_q.outBit;
    assign serialOutEn = s_q.outEn;
endmodule
